/* hw/twrm_pkg.sv */
/*
 * Constants for the two-wire register master: addresses, framing, timing.
 * Assumes a 100 MHz system clock and a bus with pull-ups on both wires.
 */
package twrm_pkg;
   localparam logic [6:0]  TWRM_ADDR_LOW   = 7'h48;  // 0x90 >> 1
   localparam logic [6:0]  TWRM_ADDR_HIGH  = 7'h5D;  // 0xBA >> 1
   localparam logic        TWRM_DIR_WRITE  = 1'b0;
   localparam logic        TWRM_DIR_READ   = 1'b1;
   localparam int          TWRM_BYTE_BITS  = 8;
   localparam int          TWRM_CLK_MHZ    = 100;
   localparam int          TWRM_SCL_NS     = 80;
   localparam int          TWRM_HALF_CYC   = (TWRM_SCL_NS * TWRM_CLK_MHZ)
                                             / 2000;
   localparam int          TWRM_QTR_CYC    = TWRM_HALF_CYC / 2;
   localparam logic [7:0]  TWRM_LEN_RESET  = 8'h02;
endpackage : twrm_pkg

/* hw/twrm_clkdiv.sv */
/*
 * Phase generator for the serial clock: quarter-period ticks.
 * Assumes a free-running system clock and a synchronous reset.
 */
`timescale 1ns/1ps
module twrm_clkdiv
   import twrm_pkg::*;
#(
   parameter int QTR = TWRM_QTR_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic run_i,
   output logic      tick_o
);
   initial begin
      if (QTR < 1) $error("twrm_clkdiv: QTR must be at least 1");
   end

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg + 16'h0001;
      if (!run_i || cnt_reg == 16'(QTR - 1)) begin
         cnt_next = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick_o = run_i && (cnt_reg == 16'(QTR - 1));
endmodule : twrm_clkdiv

/* hw/twrm_master.sv */
/*
 * Two-wire bus master that writes and reads 16-bit registers of the
 * register slave. Drives the serial clock by division of sys_clk_i.
 * Assumes open-drain wires resolved outside, with pull-ups.
 */
`timescale 1ns/1ps
module twrm_master
   import twrm_pkg::*;
#(
   parameter int MAX_LEN = 255
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        address_select_pin_i,
   input  wire logic        req_valid_i,
   output logic             req_ready_o,
   input  wire logic        req_read_i,
   input  wire logic        req_use_addr_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [7:0]  req_len_i,
   input  wire logic        wr_valid_i,
   output logic             wr_ready_o,
   input  wire logic [7:0]  wr_data_i,
   output logic             rd_valid_o,
   output logic [7:0]       rd_data_o,
   output logic             done_o,
   output logic             nack_o,
   output logic             serial_clk_o,
   output logic             serial_clk_oe_o,
   input  wire logic        serial_data_io_i,
   output logic             serial_data_io_o,
   output logic             serial_data_io_oe_o
);
   initial begin
      if (MAX_LEN < 1 || MAX_LEN > 255) $error("twrm_master: bad MAX_LEN");
   end

   typedef enum {
      TWRM_IDLE, TWRM_START, TWRM_BIT, TWRM_ACK, TWRM_RSTART, TWRM_STOP
   } twrm_state_t;
   typedef enum {
      TWRM_PH_ADDR, TWRM_PH_RA_HI, TWRM_PH_RA_LO, TWRM_PH_WDATA,
      TWRM_PH_RADDR, TWRM_PH_RDATA
   } twrm_phase_t;

   twrm_state_t st_reg, st_next;
   twrm_phase_t ph_reg, ph_next;
   logic [1:0]  q_reg, q_next;
   logic [2:0]  bit_reg, bit_next;
   logic [7:0]  sh_reg, sh_next;
   logic [7:0]  left_reg, left_next;
   logic        rd_reg, rd_next;
   logic        use_reg, use_next;
   logic [15:0] ra_reg, ra_next;
   logic        scl_reg, scl_next;
   logic        sda_low_reg, sda_low_next;
   logic        rv_reg, rv_next;
   logic [7:0]  rdat_reg, rdat_next;
   logic        done_reg, done_next;
   logic        nack_reg, nack_next;
   logic        sel_reg;
   logic [1:0]  sda_sync_reg;
   logic        tick;

   // Address select is a pin: synchronised, second stage sampled
   logic [1:0]  sel_sync_reg;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sda_sync_reg <= 2'b11;
         sel_sync_reg <= 2'b00;
         sel_reg      <= 1'b0;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], serial_data_io_i};
         sel_sync_reg <= {sel_sync_reg[0], address_select_pin_i};
         sel_reg      <= sel_sync_reg[1];
      end
   end

   twrm_clkdiv #(.QTR(TWRM_QTR_CYC)) u_div (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (st_reg != TWRM_IDLE),
      .tick_o    (tick)
   );

   function automatic logic [7:0] addr_byte(input logic sel,
                                            input logic dir);
      addr_byte = {(sel ? TWRM_ADDR_HIGH : TWRM_ADDR_LOW), dir};
   endfunction : addr_byte

   wire sda_in = sda_sync_reg[1];
   wire last_q = tick && q_reg == 2'd3;

   always_comb begin
      st_next      = st_reg;
      ph_next      = ph_reg;
      q_next       = q_reg;
      bit_next     = bit_reg;
      sh_next      = sh_reg;
      left_next    = left_reg;
      rd_next      = rd_reg;
      use_next     = use_reg;
      ra_next      = ra_reg;
      scl_next     = scl_reg;
      sda_low_next = sda_low_reg;
      rv_next      = 1'b0;
      rdat_next    = rdat_reg;
      done_next    = 1'b0;
      nack_next    = 1'b0;
      if (tick) begin
         q_next = q_reg + 2'd1;
      end
      case (st_reg)
         TWRM_IDLE: begin
            scl_next     = 1'b1;
            sda_low_next = 1'b0;
            q_next       = 2'd0;
            if (req_valid_i) begin
               rd_next   = req_read_i;
               use_next  = req_use_addr_i;
               ra_next   = req_addr_i;
               left_next = (req_len_i == 8'h00) ? TWRM_LEN_RESET : req_len_i;
               st_next   = TWRM_START;
            end
         end
         TWRM_START: begin
            if (tick && q_reg == 2'd1) begin
               sda_low_next = 1'b1;
            end
            if (tick && q_reg == 2'd2) begin
               scl_next = 1'b0;
            end
            if (last_q) begin
               bit_next = 3'd7;
               // read without address skips write phase
               if (rd_reg && !use_reg) begin
                  ph_next = TWRM_PH_RADDR;
                  sh_next = addr_byte(sel_reg, TWRM_DIR_READ);
               end else begin
                  ph_next = TWRM_PH_ADDR;
                  sh_next = addr_byte(sel_reg, TWRM_DIR_WRITE);
               end
               st_next = TWRM_BIT;
            end
         end
         TWRM_BIT: begin
            if (tick && q_reg == 2'd0) begin
               sda_low_next = (ph_reg == TWRM_PH_RDATA) ? 1'b0 : !sh_reg[7];
            end
            if (tick && q_reg == 2'd1) begin
               scl_next = 1'b1;
            end
            if (tick && q_reg == 2'd2) begin
               sh_next = {sh_reg[6:0], sda_in};
            end
            if (last_q) begin
               scl_next = 1'b0;
               bit_next = bit_reg - 3'd1;
               if (bit_reg == 3'd0) begin
                  st_next = TWRM_ACK;
               end
            end
         end
         TWRM_ACK: begin
            if (tick && q_reg == 2'd0) begin
               // master acks until the last byte
               sda_low_next = (ph_reg == TWRM_PH_RDATA) &&
                              (left_reg != 8'h01);
            end
            if (tick && q_reg == 2'd1) begin
               scl_next = 1'b1;
               if (ph_reg == TWRM_PH_RDATA) begin
                  rv_next   = 1'b1;
                  rdat_next = sh_reg;
               end
            end
            if (last_q) begin
               scl_next = 1'b0;
               bit_next = 3'd7;
               if (ph_reg != TWRM_PH_RDATA && sda_in) begin
                  nack_next = 1'b1;
                  st_next   = TWRM_STOP;
               end else begin
                  // Next byte slot unless the phase ends the frame or needs a restart
                  st_next = TWRM_BIT;
                  case (ph_reg)
                     TWRM_PH_ADDR: begin
                        ph_next = TWRM_PH_RA_HI;
                        sh_next = ra_reg[15:8];
                     end
                     TWRM_PH_RA_HI: begin
                        ph_next = TWRM_PH_RA_LO;
                        sh_next = ra_reg[7:0];
                     end
                     TWRM_PH_RA_LO: begin
                        if (rd_reg) begin
                           st_next = TWRM_RSTART;
                        end else begin
                           ph_next = TWRM_PH_WDATA;
                           sh_next = wr_data_i;
                        end
                     end
                     TWRM_PH_WDATA: begin
                        left_next = left_reg - 8'h01;
                        sh_next   = wr_data_i;
                        if (left_reg == 8'h01) begin
                           st_next = TWRM_STOP;
                        end
                     end
                     TWRM_PH_RADDR: begin
                        ph_next = TWRM_PH_RDATA;
                     end
                     default: begin
                        left_next = left_reg - 8'h01;
                        if (left_reg == 8'h01) begin
                           st_next = TWRM_STOP;
                        end
                     end
                  endcase
               end
            end
         end
         TWRM_RSTART: begin
            if (tick && q_reg == 2'd0) begin
               sda_low_next = 1'b0;
            end
            if (tick && q_reg == 2'd1) begin
               scl_next = 1'b1;
            end
            if (tick && q_reg == 2'd2) begin
               sda_low_next = 1'b1;
            end
            if (last_q) begin
               scl_next = 1'b0;
               ph_next  = TWRM_PH_RADDR;
               sh_next  = addr_byte(sel_reg, TWRM_DIR_READ);
               bit_next = 3'd7;
               st_next  = TWRM_BIT;
            end
         end
         TWRM_STOP: begin
            if (tick && q_reg == 2'd0) begin
               sda_low_next = 1'b1;
            end
            if (tick && q_reg == 2'd1) begin
               scl_next = 1'b1;
            end
            if (tick && q_reg == 2'd2) begin
               sda_low_next = 1'b0;
            end
            if (last_q) begin
               done_next = 1'b1;
               st_next   = TWRM_IDLE;
            end
         end
         default: begin
            st_next = TWRM_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_reg      <= TWRM_IDLE;
         ph_reg      <= TWRM_PH_ADDR;
         q_reg       <= 2'd0;
         bit_reg     <= 3'd7;
         sh_reg      <= 8'h00;
         left_reg    <= 8'h00;
         rd_reg      <= 1'b0;
         use_reg     <= 1'b0;
         ra_reg      <= 16'h0000;
         scl_reg     <= 1'b1;
         sda_low_reg <= 1'b0;
         rv_reg      <= 1'b0;
         rdat_reg    <= 8'h00;
         done_reg    <= 1'b0;
         nack_reg    <= 1'b0;
      end else begin
         st_reg      <= st_next;
         ph_reg      <= ph_next;
         q_reg       <= q_next;
         bit_reg     <= bit_next;
         sh_reg      <= sh_next;
         left_reg    <= left_next;
         rd_reg      <= rd_next;
         use_reg     <= use_next;
         ra_reg      <= ra_next;
         scl_reg     <= scl_next;
         sda_low_reg <= sda_low_next;
         rv_reg      <= rv_next;
         rdat_reg    <= rdat_next;
         done_reg    <= done_next;
         nack_reg    <= nack_next;
      end
   end

   // Write data is taken when the byte loads, on the ack's last quarter
   assign req_ready_o = (st_reg == TWRM_IDLE);
   assign wr_ready_o  = (st_reg == TWRM_ACK) && last_q && !sda_in &&
                        (ph_reg == TWRM_PH_RA_LO && !rd_reg ||
                         ph_reg == TWRM_PH_WDATA && left_reg != 8'h01);
   assign rd_valid_o  = rv_reg;
   assign rd_data_o   = rdat_reg;
   assign done_o      = done_reg;
   assign nack_o      = nack_reg;
   // Open drain: clock only pulled low, released high
   assign serial_clk_o        = 1'b0;
   assign serial_clk_oe_o     = !scl_reg;
   assign serial_data_io_o    = 1'b0;
   assign serial_data_io_oe_o = sda_low_reg;

   // start is data falling while clock high
   a_start_form: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_START && $rose(sda_low_reg)) |-> scl_reg);
   // stop is data rising while clock high
   a_stop_form: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_STOP && $fell(sda_low_reg)) |-> scl_reg);
   // data only changes while clock low within a bit slot
   a_data_stable: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_BIT && scl_reg && $past(scl_reg))
      |-> $stable(sda_low_reg));
   // last read byte gets no acknowledge
   a_last_nack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_ACK && ph_reg == TWRM_PH_RDATA && left_reg == 8'h01
       && scl_reg) |-> !sda_low_reg);
   a_mid_ack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_ACK && ph_reg == TWRM_PH_RDATA && left_reg > 8'h01
       && scl_reg) |-> sda_low_reg);
   // master releases data in every ack slot except the read data ones
   a_ack_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_reg == TWRM_ACK && ph_reg != TWRM_PH_RDATA && scl_reg)
      |-> !sda_low_reg);
   a_nack_stop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      nack_reg |-> st_reg == TWRM_STOP);
   // done follows stop and returns to idle
   a_done_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      done_reg |-> st_reg == TWRM_IDLE && !sda_low_reg && scl_reg);

   c_write: cover property (@(posedge sys_clk_i)
      ph_reg == TWRM_PH_WDATA && done_next);
   c_read: cover property (@(posedge sys_clk_i) rv_reg);
   c_nack: cover property (@(posedge sys_clk_i) nack_reg);
   c_rstart: cover property (@(posedge sys_clk_i) st_reg == TWRM_RSTART);
endmodule : twrm_master

/* dv/twrm_slave_model.sv */
/*
 * Behavioural register slave on the two-wire bus: 256 words of 16 bits.
 * Assumes the bench resolves both open-drain wires with pull-ups.
 */
`timescale 1ns/1ps
module twrm_slave_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic sel_i,
   output logic      sda_oe_o
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AH, S_AL, S_WR, S_RD} twrm_ph_t;
   twrm_ph_t    ph;
   logic [15:0] regs [0:255];
   logic [15:0] ptr;
   logic [7:0]  sh, hold, txb;
   logic        lo, mack;
   int          bitn;

   initial begin
      for (int i = 0; i < 256; i++) regs[i] = {8'(i) ^ 8'h5A, 8'(i)};
      ph = S_IDLE;
      ptr = 16'h0000;
      sda_oe_o = 1'b0;
   end

   // Start or restart: pointer kept, only framing resets
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      ph = S_ADDR;
      bitn = 0;
      lo = 1'b0;
   end

   always @(posedge sda_i) if (scl_i === 1'b1) begin
      ph = S_IDLE;
      sda_oe_o = 1'b0;
   end

   always @(posedge scl_i) if (ph != S_IDLE) begin
      if (bitn < 8) sh = {sh[6:0], sda_i};
      else mack = !sda_i;
      bitn = (bitn == 8) ? 0 : bitn + 1;
   end

   // Drives only while the clock is low, so no false start or stop
   always @(negedge scl_i) if (ph != S_IDLE) begin
      sda_oe_o = 1'b0;
      if (bitn == 8 && ph != S_RD) begin
         sda_oe_o = 1'b1;
         case (ph)
            S_ADDR: begin
               if (sh[7:1] != (sel_i ? 7'h5D : 7'h48)) begin
                  sda_oe_o = 1'b0;
                  ph = S_IDLE;
               end
               else ph = sh[0] ? S_RD : S_AH;
            end
            S_AH: begin
               ptr[15:8] = sh;
               ph = S_AL;
            end
            S_AL: begin
               ptr[7:0] = sh;
               ph = S_WR;
            end
            default: begin
               if (lo) begin
                  regs[ptr[7:0]] = {hold, sh};
                  ptr++;
               end
               else hold = sh;
               lo = !lo;
            end
         endcase
      end
      else if (ph == S_RD && bitn == 0) begin
         if (!mack) ph = S_IDLE;
         else begin
            txb = lo ? regs[ptr[7:0]][7:0] : regs[ptr[7:0]][15:8];
            if (lo) ptr++;
            lo = !lo;
            sda_oe_o = !txb[7];
         end
      end
      else if (ph == S_RD && bitn < 8) sda_oe_o = !txb[7 - bitn];
   end
endmodule : twrm_slave_model

/* dv/tb_twrm_master.sv */
/*
 * Self-checking bench for the two-wire register master.
 * Assumes the slave model in this folder; wires resolved with pull-ups.
 */
`timescale 1ns/1ps
module tb_twrm_master;
   logic        sys_clk, sys_rst, sel_m, sel_s, wr_valid;
   logic        req_valid, req_read, req_use, req_ready;
   logic [15:0] req_addr;
   logic [7:0]  req_len, wr_data, rd_data;
   logic        wr_ready, rd_valid, done, nack;
   logic        scl_oe, sda_oe_m, sda_oe_s, scl, sda;
   logic        scl_o, sda_o_m;
   logic [7:0]  wb [0:7];
   logic [7:0]  rq [$];
   int          wi, n_done, n_nack, n_fail, compares;

   // Open drain with pull-ups
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_oe_m ? sda_o_m : 1'b1) & ~sda_oe_s;

   twrm_master dut (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .address_select_pin_i(sel_m),
      .req_valid_i(req_valid), .req_ready_o(req_ready),
      .req_read_i(req_read), .req_use_addr_i(req_use),
      .req_addr_i(req_addr), .req_len_i(req_len), .wr_valid_i(wr_valid),
      .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .done_o(done), .nack_o(nack),
      .serial_clk_o(scl_o), .serial_clk_oe_o(scl_oe), .serial_data_io_i(sda),
      .serial_data_io_o(sda_o_m), .serial_data_io_oe_o(sda_oe_m));

   twrm_slave_model slave (.scl_i(scl), .sda_i(sda), .sel_i(sel_s),
                           .sda_oe_o(sda_oe_s));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) if (wr_ready === 1'b1) wi <= wi + 1;

   // Pulses last one cycle, so they are sampled mid-cycle
   always @(negedge sys_clk) begin
      wr_data <= wb[wi[2:0]];
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (done === 1'b1) n_done++;
      if (nack === 1'b1) n_nack++;
   end

   function automatic logic [15:0] init_word(input logic [7:0] a);
      return {a ^ 8'h5A, a};
   endfunction : init_word

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   task automatic xfer(input logic rd, input logic use_a,
                       input logic [15:0] a, input logic [7:0] n);
      int k;
      int d0;
      int q0;
      d0 = n_done;
      q0 = n_nack;
      k = 0;
      rq.delete();
      wi = 0;
      req_read = rd;
      req_use = use_a;
      req_addr = a;
      req_len = n;
      req_valid = 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      req_valid = 1'b0;
      while (n_done == d0 && n_nack == q0 && k < 4000) begin
         @(negedge sys_clk);
         k++;
      end
      while (req_ready !== 1'b1 && k < 4200) begin
         @(negedge sys_clk);
         k++;
      end
      chk(16'(k < 4000), 16'h0001);
      chk({14'h0000, scl, sda}, 16'h0003);
   endtask : xfer

   task automatic t_write_read;
      wb[0] = 8'hA5;
      wb[1] = 8'h3C;
      xfer(1'b0, 1'b0, 16'h1234, 8'h02);
      chk(16'(n_nack), 16'h0000);
      xfer(1'b1, 1'b1, 16'h1234, 8'h02);
      chk(16'(rq.size()), 16'h0002);
      chk({rq[0], rq[1]}, 16'hA53C);
   endtask : t_write_read

   task automatic t_sequential;
      wb[0] = 8'h11;
      wb[1] = 8'h22;
      wb[2] = 8'h33;
      wb[3] = 8'h44;
      xfer(1'b0, 1'b0, 16'h0020, 8'h04);
      xfer(1'b1, 1'b1, 16'h0020, 8'h06);
      chk({rq[0], rq[1]}, 16'h1122);
      chk({rq[2], rq[3]}, 16'h3344);
      chk({rq[4], rq[5]}, init_word(8'h22));
      // Current location with length zero, taken as two
      xfer(1'b1, 1'b0, 16'hFFFF, 8'h00);
      chk(16'(rq.size()), 16'h0002);
      chk({rq[0], rq[1]}, init_word(8'h23));
   endtask : t_sequential

   task automatic t_select;
      int q0;
      sel_m = 1'b1;
      sel_s = 1'b1;
      repeat (5) @(negedge sys_clk);
      xfer(1'b1, 1'b1, 16'h0005, 8'h02);
      chk({rq[0], rq[1]}, init_word(8'h05));
      sel_s = 1'b0;
      repeat (5) @(negedge sys_clk);
      q0 = n_nack;
      xfer(1'b1, 1'b1, 16'h0005, 8'h02);
      chk(16'(n_nack - q0), 16'h0001);
      chk(16'(rq.size()), 16'h0000);
   endtask : t_select

   initial begin
      n_fail = 0;
      compares = 0;
      n_done = 0;
      n_nack = 0;
      wi = 0;
      sys_rst = 1'b1;
      sel_m = 1'b0;
      sel_s = 1'b0;
      wr_valid = 1'b1;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_use = 1'b0;
      req_addr = 16'h0000;
      req_len = 8'h02;
      wr_data = 8'h00;
      for (int i = 0; i < 8; i++) wb[i] = 8'h00;
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_write_read;
      t_sequential;
      t_select;
      test_done;
   end

   // Seven frames of under a thousand cycles each
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      test_done;
   end
endmodule : tb_twrm_master
